// >>> hscr_dev.sv
/*
  device end: status, alternate status, command, fixed-disk control and loopback registers.
  assumes the host bus is synchronous to mclk_i; drive status lines and the local reset pin are async.
*/
`timescale 1ns/10ps
`include "hscr_defs.svh"
module hscr_dev (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       srst_i,
  // host bus
  hscr_if.dev             hb,
  // async pins
  input  wire logic       local_reset_n_i,
  input  wire logic       drv_index_i,
  input  wire logic       drv_seek_done_i,
  input  wire logic       drv_write_fault_i,
  input  wire logic       drv_ready_i,
  // local controller events
  input  wire logic       busy_clear_i,
  input  wire logic       error_set_i,
  input  wire logic       ecc_set_i,
  input  wire logic       drq_set_i,
  input  wire logic       drq_clear_i,
  input  wire logic       irq_raise_i,
  // dma
  input  wire logic       dma_mode_sel_i,
  input  wire logic       dma_ctrl_en_i,
  input  wire logic       dma_req_i,
  // cable
  input  wire logic       write_gate_n_i,
  input  wire logic       cable_sel_load_i,
  input  wire logic [5:0] cable_sel_n_i,
  output logic      [5:0] cable_sel_n_o,
  // command and control out
  output logic            cmd_valid_o,
  output logic      [7:0] cmd_code_o,
  output logic            xfer_abort_o,
  output logic            soft_reset_o,
  output logic            head_sel3_enable_o,
  output logic            irq_pending_o
);
  //////////////////////////////////////////////////////////////////////////////
  logic [3:0]           pins_s;
  logic                 local_rst_s;
  logic                 write_gate_n_s;
  logic                 hard_rst;
  logic                 cmd_wr;
  logic                 fdc_wr;
  logic                 st_rd;
  logic                 busy;
  logic                 err;
  logic                 corr;
  logic                 transfer_request_bit;
  logic                 irq_pend;
  logic [7:0]           rdata;
  logic [7:0]           rdata_oe;
  hscr_pkg::hscr_fdc_t  fdc;
  hscr_pkg::hscr_status_t status;

  // pins are async: two flops before any logic
  hscr_sync2 #(.W(6)) u_sync (
    .mclk_i  (mclk_i),
    .srst_i  (srst_i),
    .async_i ({write_gate_n_i, ~local_reset_n_i, drv_ready_i, drv_write_fault_i, drv_seek_done_i, drv_index_i}),
    .sync_o  ({write_gate_n_s, local_rst_s, pins_s})
  );

  // srst, local pin and host pin all count as hard reset
  assign hard_rst = srst_i | local_rst_s | hb.host_reset_pin;

  function automatic logic hit(input logic ctl, input logic [2:0] ofs);
    hit = (hb.ctl_sel == ctl) && (hb.addr == ofs);
  endfunction

  // no lockout while data request is up: every access lands
  assign cmd_wr = hb.wr & hit(1'b0, `HSCR_OFS_STATUS);
  assign fdc_wr = hb.wr & hit(1'b1, `HSCR_OFS_ALT_FDC);
  assign st_rd  = hb.rd & hit(1'b0, `HSCR_OFS_STATUS);

  //////////////////////////////////////////////////////////////////////////////
  // fixed-disk control; upper bits are don't care and dropped
  always_ff @(posedge mclk_i) begin
    if (hard_rst) begin
      fdc <= `HSCR_FDC_RESET;
    end else if (fdc_wr) begin
      fdc <= hb.wdata & `HSCR_FDC_USED_MASK;
    end
  end

  assign soft_reset_o       = fdc.soft_rst;
  assign head_sel3_enable_o = fdc.head3;

  //////////////////////////////////////////////////////////////////////////////
  // busy: any set source wins over the clear from the local controller
  always_ff @(posedge mclk_i) begin
    if (hard_rst) begin
      busy <= 1'b1;
    end else if (cmd_wr || (fdc_wr && hb.wdata[`HSCR_FDC_SOFT_RST]) || fdc.soft_rst) begin
      busy <= 1'b1;
    end else if (busy_clear_i) begin
      busy <= 1'b0;
    end
  end

  // error and corrected-data: set wins over the command-write clear
  always_ff @(posedge mclk_i) begin
    if (hard_rst) begin
      err  <= 1'b0;
      corr <= 1'b0;
    end else begin
      err  <= error_set_i | (err & ~cmd_wr);
      corr <= ecc_set_i | (corr & ~cmd_wr);
    end
  end

  // data request; a command write abandons the transfer in flight
  always_ff @(posedge mclk_i) begin
    if (hard_rst) begin
      transfer_request_bit <= 1'b0;
    end else if (drq_set_i) begin
      transfer_request_bit <= 1'b1;
    end else if (cmd_wr || drq_clear_i) begin
      transfer_request_bit <= 1'b0;
    end
  end

  // command hand-off to the local controller
  always_ff @(posedge mclk_i) begin
    if (hard_rst) begin
      cmd_valid_o  <= 1'b0;
      cmd_code_o   <= 8'h00;
      xfer_abort_o <= 1'b0;
    end else begin
      cmd_valid_o  <= cmd_wr;
      xfer_abort_o <= cmd_wr & transfer_request_bit;
      if (cmd_wr) begin
        cmd_code_o <= hb.wdata;
      end
    end
  end

  // pending host interrupt: raise wins, only primary status read clears
  always_ff @(posedge mclk_i) begin
    if (hard_rst) begin
      irq_pend <= 1'b0;
    end else if (irq_raise_i) begin
      irq_pend <= 1'b1;
    end else if (st_rd) begin
      irq_pend <= 1'b0;
    end
  end

  assign irq_pending_o = irq_pend;
  assign hb.irq        = irq_pend & ~fdc.irq_en_n;

  // dma gate bites only with both local enables set
  assign hb.transfer_request_flag = dma_req_i & (~(dma_mode_sel_i & dma_ctrl_en_i) | fdc.dma_gate);

  //////////////////////////////////////////////////////////////////////////////
  // cable selects follow the drive/head register reset conditions
  always_ff @(posedge mclk_i) begin
    if (hard_rst || fdc.soft_rst || (cmd_wr && hb.wdata == `HSCR_CMD_DIAG)) begin
      cable_sel_n_o <= `HSCR_LB_SEL_RESET;
    end else if (cable_sel_load_i) begin
      cable_sel_n_o <= cable_sel_n_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status image; other bits are live even while busy, host end keeps only busy and data request
  always_comb begin
    status       = '0;
    status.busy  = busy;
    status.ready = pins_s[3];
    status.fault = pins_s[2];
    status.seek  = pins_s[1];
    status.transfer_request_bit   = transfer_request_bit;
    status.corr  = corr;
    status.index = pins_s[0] & pins_s[3];
    status.err   = err;
  end

  // read data registered one cycle after the strobe
  always_comb begin
    rdata    = 8'h00;
    rdata_oe = 8'hff;
    if (hit(1'b0, `HSCR_OFS_STATUS) || hit(1'b1, `HSCR_OFS_ALT_FDC)) begin
      rdata = status;
    end else if (hit(1'b1, `HSCR_OFS_LOOPBACK)) begin
      rdata    = {1'b0, write_gate_n_s, cable_sel_n_o};
      rdata_oe = `HSCR_LB_DRIVEN_OE;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      hb.rdata    <= 8'h00;
      hb.rdata_oe <= 8'h00;
    end else if (hb.rd) begin
      hb.rdata    <= rdata;
      hb.rdata_oe <= rdata_oe;
    end else begin
      hb.rdata_oe <= 8'h00;
    end
  end
endmodule

// >>> hscr_defs.svh
/*
  offsets, field positions, reset values and command codes of the host status and control register group.
  assumes it is included by bare name from every file that needs a number.
*/
`ifndef HSCR_DEFS_SVH
`define HSCR_DEFS_SVH

// host bus offsets, task block (ctl select low) and control block (ctl select high)
`define HSCR_OFS_STATUS      3'h7
`define HSCR_OFS_ALT_FDC     3'h6
`define HSCR_OFS_LOOPBACK    3'h7

// status field positions
`define HSCR_ST_ERR          0
`define HSCR_ST_INDEX        1
`define HSCR_ST_CORR         2
`define HSCR_ST_DRQ          3
`define HSCR_ST_SEEK         4
`define HSCR_ST_FAULT        5
`define HSCR_ST_READY        6
`define HSCR_ST_BUSY         7

// fixed-disk control field positions and reset value
`define HSCR_FDC_DMA         0
`define HSCR_FDC_IRQ_EN_N    1
`define HSCR_FDC_SOFT_RST    2
`define HSCR_FDC_HEAD3       3
`define HSCR_FDC_USED_MASK   8'h0f
`define HSCR_FDC_RESET       8'h00

// loopback: bit 6 write gate, bits 5-0 cable selects (active low)
`define HSCR_LB_WRITE_GATE_N        6
`define HSCR_LB_SEL_RESET    6'h3f
`define HSCR_LB_DRIVEN_OE    8'h7f

// diagnostic command code
`define HSCR_CMD_DIAG        8'h90

// host side software map
`define HSCR_SW_CTL_BIT      3
`define HSCR_SW_OWN          4'h8
`define HSCR_OWN_HRST        0
`define HSCR_OWN_IRQ         1
`define HSCR_OWN_TRANSFER_REQUEST_FLAG        2
`define HSCR_OWN_REFUSED     3
`define HSCR_OWN_BUSY        4

`endif

// >>> hscr_pkg.sv
/*
  types used by the device end of the host status and control link.
  assumes hscr_defs.svh supplies the numbers.
*/
package hscr_pkg;

  typedef struct packed {
    logic busy;
    logic ready;
    logic fault;
    logic seek;
    logic transfer_request_bit;
    logic corr;
    logic index;
    logic err;
  } hscr_status_t;

  typedef struct packed {
    logic [3:0] unused;
    logic       head3;
    logic       soft_rst;
    logic       irq_en_n;
    logic       dma_gate;
  } hscr_fdc_t;

endpackage

// >>> hscr_if.sv
/*
  host bus between the host end and the device end.
  assumes both ends run on the same mclk_i; bit 7 of read data is only valid where its enable is high.
*/
`timescale 1ns/10ps
interface hscr_if;
  logic [2:0] addr;
  logic       ctl_sel;
  logic       rd;
  logic       wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic [7:0] rdata_oe;
  logic       irq;
  logic       transfer_request_flag;
  logic       host_reset_pin;

  modport dev (
    input  addr, ctl_sel, rd, wr, wdata, host_reset_pin,
    output rdata, rdata_oe, irq, transfer_request_flag
  );
  modport host (
    output addr, ctl_sel, rd, wr, wdata, host_reset_pin,
    input  rdata, rdata_oe, irq, transfer_request_flag
  );
endinterface

// >>> hscr_sync2.sv
/*
  two-flop synchroniser for levels arriving from pins.
  assumes the inputs are quasi-static levels; multi-bit groups may skew by one cycle.
*/
`timescale 1ns/10ps
module hscr_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         mclk_i,
  input  wire logic         srst_i,
  // levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      meta   <= '0;
      sync_o <= '0;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule

// >>> hscr_host.sv
/*
  host end: turns a plain software port into host bus cycles and keeps the host's access discipline.
  assumes the device end shares mclk_i; read data stands one cycle after the read strobe.
*/
`timescale 1ns/10ps
`include "hscr_defs.svh"
module hscr_host (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       srst_i,
  // software port
  input  wire logic [3:0] sw_addr_i,
  input  wire logic [7:0] sw_wdata_i,
  input  wire logic       sw_wr_i,
  input  wire logic       sw_rd_i,
  output logic      [7:0] sw_rdata_o,
  // host bus
  hscr_if.host            hb
);
  //////////////////////////////////////////////////////////////////////////////
  logic       busy_seen;
  logic       drq_seen;
  logic       own_hit;
  logic       ctl;
  logic       allowed;
  logic       refused;
  logic       own_rd_q;
  logic       refused_rd_q;
  logic       status_rd_q;
  logic [7:0] own_word;

  assign own_hit = (sw_addr_i == `HSCR_SW_OWN);
  assign ctl     = sw_addr_i[`HSCR_SW_CTL_BIT];

  // while busy with no data request seen, only status reads and any control block access (alternate status, fixed-disk, loopback)
  // new command only when idle; a data request permits abort
  always_comb begin
    allowed = 1'b1;
    if (!ctl && sw_addr_i[2:0] == `HSCR_OFS_STATUS) begin
      allowed = sw_rd_i || !busy_seen || drq_seen;
    end else if (!ctl) begin
      allowed = !busy_seen || drq_seen;
    end
  end

  assign hb.addr    = sw_addr_i[2:0];
  assign hb.ctl_sel = ctl;
  assign hb.rd      = sw_rd_i & ~own_hit & allowed;
  assign hb.wr      = sw_wr_i & ~own_hit & allowed;
  // upper control bits written as zero
  assign hb.wdata   = (ctl && sw_addr_i[2:0] == `HSCR_OFS_ALT_FDC) ? (sw_wdata_i & `HSCR_FDC_USED_MASK) : sw_wdata_i;

  //////////////////////////////////////////////////////////////////////////////
  // last status seen; until a read, assume busy as after reset
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      busy_seen <= 1'b1;
      drq_seen  <= 1'b0;
    end else if (status_rd_q) begin
      busy_seen <= hb.rdata[`HSCR_ST_BUSY];
      drq_seen  <= hb.rdata[`HSCR_ST_DRQ];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      status_rd_q  <= 1'b0;
      own_rd_q     <= 1'b0;
      refused_rd_q <= 1'b0;
    end else begin
      status_rd_q  <= hb.rd && (ctl ? (sw_addr_i[2:0] == `HSCR_OFS_ALT_FDC) : (sw_addr_i[2:0] == `HSCR_OFS_STATUS));
      own_rd_q     <= sw_rd_i & own_hit;
      refused_rd_q <= sw_rd_i & ~own_hit & ~allowed;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // own register: host reset pin drive, refused sticky (set wins over clear)
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      hb.host_reset_pin <= 1'b0;
      refused           <= 1'b0;
    end else begin
      if (sw_wr_i && own_hit) begin
        hb.host_reset_pin <= sw_wdata_i[`HSCR_OWN_HRST];
      end
      if ((sw_wr_i || sw_rd_i) && !own_hit && !allowed) begin
        refused <= 1'b1;
      end else if (sw_wr_i && own_hit && sw_wdata_i[`HSCR_OWN_REFUSED]) begin
        refused <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      own_word <= 8'h00;
    end else if (sw_rd_i && own_hit) begin
      own_word <= {3'h0, busy_seen, refused, hb.transfer_request_flag, hb.irq, hb.host_reset_pin};
    end
  end

  // floating bits read as zero; refused reads return zero
  always_comb begin
    if (own_rd_q) begin
      sw_rdata_o = own_word;
    end else if (refused_rd_q) begin
      sw_rdata_o = 8'h00;
    end else begin
      sw_rdata_o = hb.rdata & hb.rdata_oe;
    end
  end
endmodule

// >>> hscr_properties.sv
/*
  checker for the host bus that joins hscr_host and hscr_dev.
  assumes the testbench wires it to the interface signals by name.
*/
`timescale 1ns/10ps
module hscr_properties (
  // clock and reset
  input  wire logic       mclk_i,
  input  wire logic       srst_i,
  // host bus
  input  wire logic [2:0] addr,
  input  wire logic       ctl_sel,
  input  wire logic       rd,
  input  wire logic       wr,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] rdata,
  input  wire logic [7:0] rdata_oe,
  input  wire logic       irq,
  input  wire logic       transfer_request_flag,
  input  wire logic       host_reset_pin
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  wire logic st;
  wire logic fd;
  logic      en_n;
  assign st = !ctl_sel && addr == 3'h7;
  assign fd = ctl_sel && addr == 3'h6;

  // last enable-low bit seen on the bus; the pin resets it like the device does
  always_ff @(posedge mclk_i) begin
    if (srst_i || host_reset_pin) en_n <= 1'b0;
    else if (wr && fd) en_n <= wdata[1];
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence cmd_then_status;
    wr && st ##2 rd && st;
  endsequence
  sequence soft_then_status;
    wr && fd && wdata[2] ##2 rd && st;
  endsequence

  AST_STATUS_OE: assert property (rd && st |=> rdata_oe == 8'hff)
    else $error("status read not driven on every bit");
  AST_IDLE_OE: assert property (!rd |=> rdata_oe == 8'h00)
    else $error("data driven outside a read answer");
  AST_LOOP_OE: assert property (rd && ctl_sel && addr == 3'h7 |=> rdata_oe == 8'h7f)
    else $error("loopback read did not float bit 7 alone");
  AST_RD_CLEARS_IRQ: assert property (rd && st |=> !irq)
    else $error("status read left the interrupt up");
  AST_ALT_KEEPS_IRQ: assert property (rd && fd && irq |=> irq)
    else $error("alternate status read dropped the interrupt");
  AST_CMD_BUSY: assert property (cmd_then_status |=> rdata[7])
    else $error("command did not set busy");
  AST_CMD_CLEARS: assert property (cmd_then_status |=> !rdata[0] && !rdata[2])
    else $error("command did not clear error or corrected bit");
  AST_SOFT_BUSY: assert property (soft_then_status |=> rdata[7])
    else $error("soft reset did not set busy");
  AST_IRQ_GATED: assert property (irq |-> !en_n)
    else $error("interrupt while enable-low bit is one");
  AST_HRST_IRQ: assert property (host_reset_pin |=> !irq)
    else $error("interrupt survived the host reset pin");
endmodule

// >>> tb.sv
/*
  testbench: hscr_host and hscr_dev joined by hscr_if, driven through the software port.
  assumes the design files and hscr_properties.sv are compiled before it.
*/
`timescale 1ns/10ps
module tb;
  logic       mclk_i = 1'b0;
  logic       srst_i = 1'b1;
  logic [3:0] sw_addr_i = 4'h0;
  logic [7:0] sw_wdata_i = 8'h00;
  logic       sw_wr_i = 1'b0;
  logic       sw_rd_i = 1'b0;
  logic [7:0] sw_rdata_o;
  logic [3:0] drv = 4'hb; // ready, fault, seek, index
  logic [6:0] ev = 7'h00; // load, irq, drq clr, drq set, ecc, err, busy clr
  logic [2:0] dma = 3'h0; // request, control enable, mode
  logic       wg = 1'b1; // write gate pin, inactive
  logic [5:0] cable_sel_n_o;
  logic [7:0] cmd_code_o;
  logic       cmd_valid_o;
  logic       xfer_abort_o;
  logic       soft_reset_o;
  logic       head_sel3_enable_o;
  logic       irq_pending_o;
  int         fails = 0;
  int         total_checks = 0;

  always #2.5 mclk_i = ~mclk_i;

  hscr_if hb ();
  hscr_host i_hscr_host (.mclk_i(mclk_i), .srst_i(srst_i), .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i),
    .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o), .hb(hb.host));
  hscr_dev i_hscr_dev (.mclk_i(mclk_i), .srst_i(srst_i), .hb(hb.dev), .local_reset_n_i(1'b1),
    .drv_index_i(drv[0]), .drv_seek_done_i(drv[1]), .drv_write_fault_i(drv[2]), .drv_ready_i(drv[3]),
    .busy_clear_i(ev[0]), .error_set_i(ev[1]), .ecc_set_i(ev[2]), .drq_set_i(ev[3]), .drq_clear_i(ev[4]),
    .irq_raise_i(ev[5]), .dma_mode_sel_i(dma[0]), .dma_ctrl_en_i(dma[1]), .dma_req_i(dma[2]),
    .write_gate_n_i(wg), .cable_sel_load_i(ev[6]), .cable_sel_n_i(6'h15), .cable_sel_n_o(cable_sel_n_o),
    .cmd_valid_o(cmd_valid_o), .cmd_code_o(cmd_code_o), .xfer_abort_o(xfer_abort_o),
    .soft_reset_o(soft_reset_o), .head_sel3_enable_o(head_sel3_enable_o), .irq_pending_o(irq_pending_o));
  hscr_properties i_hscr_properties (.mclk_i(mclk_i), .srst_i(srst_i), .addr(hb.addr), .ctl_sel(hb.ctl_sel),
    .rd(hb.rd), .wr(hb.wr), .wdata(hb.wdata), .rdata(hb.rdata), .rdata_oe(hb.rdata_oe), .irq(hb.irq),
    .transfer_request_flag(hb.transfer_request_flag), .host_reset_pin(hb.host_reset_pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    sw_addr_i <= a;
    sw_wdata_i <= d;
    sw_wr_i <= 1'b1;
    @(posedge mclk_i);
    sw_wr_i <= 1'b0;
    #1;
  endtask
  // read data stands only in the cycle after the strobe, so it is taken there
  task automatic rc(input string n, input logic [3:0] a, input logic [7:0] e);
    @(posedge mclk_i);
    sw_addr_i <= a;
    sw_rd_i <= 1'b1;
    @(posedge mclk_i);
    sw_rd_i <= 1'b0;
    #1;
    chk(n, sw_rdata_o, e);
  endtask
  task automatic pulse(input int i);
    @(posedge mclk_i);
    ev[i] <= 1'b1;
    @(posedge mclk_i);
    ev[i] <= 1'b0;
    #1;
  endtask
  // drive lines pass a two-flop synchroniser, hence the wait
  task automatic setd(input logic [3:0] d);
    @(posedge mclk_i);
    drv <= d;
    repeat (4) @(posedge mclk_i);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #20000;
    fails++;
    print_verdict();
  end

  initial begin
    repeat (8) @(posedge mclk_i);
    srst_i <= 1'b0;
    // drive lines need two flops after reset before status shows them
    repeat (3) @(posedge mclk_i);
    rc("status", 4'h7, 8'hd2);
    pulse(0);
    rc("status", 4'h7, 8'h52);
    rc("own", 4'h8, 8'h00);
    setd(4'h3);
    rc("index", 4'h7, 8'h10);
    setd(4'hf);
    rc("fault", 4'h7, 8'h72);
    setd(4'hb);
    $display("test mirrors done");
    pulse(1);
    pulse(2);
    rc("err", 4'h7, 8'h57);
    wr(4'h7, 8'h20);
    chk("valid", {7'h00, cmd_valid_o}, 8'h01);
    rc("cmd", 4'h7, 8'hd2);
    wr(4'h2, 8'h11);
    wr(4'h7, 8'h40);
    chk("refuse", cmd_code_o, 8'h20);
    rc("task", 4'h2, 8'h00);
    rc("own", 4'h8, 8'h18);
    wr(4'h8, 8'h08);
    rc("own", 4'h8, 8'h10);
    $display("test command done");
    pulse(3);
    rc("drq", 4'h7, 8'hda);
    wr(4'h7, 8'h30);
    chk("abort", {6'h00, xfer_abort_o, cmd_valid_o}, 8'h03);
    rc("drq", 4'h7, 8'hd2);
    chk("code", cmd_code_o, 8'h30);
    pulse(3);
    pulse(4);
    rc("drq", 4'h7, 8'hd2);
    pulse(0);
    rc("status", 4'h7, 8'h52);
    $display("test transfer done");
    wr(4'he, 8'h00);
    pulse(5);
    rc("own", 4'h8, 8'h02);
    rc("alt", 4'he, 8'h52);
    rc("own", 4'h8, 8'h02);
    rc("status", 4'h7, 8'h52);
    rc("own", 4'h8, 8'h00);
    wr(4'he, 8'h02);
    pulse(5);
    chk("pend", {7'h00, irq_pending_o}, 8'h01);
    rc("own", 4'h8, 8'h00);
    wr(4'he, 8'h00);
    rc("own", 4'h8, 8'h02);
    rc("status", 4'h7, 8'h52);
    $display("test interrupt done");
    @(posedge mclk_i);
    dma <= 3'h4;
    rc("transfer_request_flag", 4'h8, 8'h04);
    @(posedge mclk_i);
    dma <= 3'h7;
    rc("transfer_request_flag", 4'h8, 8'h00);
    wr(4'he, 8'h01);
    rc("transfer_request_flag", 4'h8, 8'h04);
    @(posedge mclk_i);
    dma <= 3'h0;
    $display("test dma done");
    pulse(6);
    chk("load", {2'h0, cable_sel_n_o}, 8'h15);
    wr(4'he, 8'h0c);
    rc("soft", 4'h7, 8'hd2);
    chk("ctl", {soft_reset_o, head_sel3_enable_o, cable_sel_n_o}, 8'hff);
    wr(4'he, 8'h08);
    pulse(0);
    rc("status", 4'h7, 8'h52);
    chk("ctl", {soft_reset_o, head_sel3_enable_o, cable_sel_n_o}, 8'h7f);
    wr(4'h8, 8'h01);
    wr(4'h8, 8'h00);
    chk("hrst", {soft_reset_o, head_sel3_enable_o, cable_sel_n_o}, 8'h3f);
    rc("hrst", 4'h7, 8'hd2);
    pulse(0);
    rc("status", 4'h7, 8'h52);
    pulse(6);
    wr(4'h7, 8'h90);
    rc("diag", 4'h7, 8'hd2);
    chk("diag", {2'h0, cable_sel_n_o}, 8'h3f);
    rc("loop", 4'hf, 8'h7f);
    $display("test resets done");
    print_verdict();
  end
endmodule
